// ==== rtl/l2ecr_map.vh ====
// Encodings, field positions and reset values for the L2 control and base registers
`ifndef L2ECR_MAP_VH
`define L2ECR_MAP_VH
`define L2ECR_CP_NUM 4'h0f
`define L2ECR_ECTL_OPC1 3'h1
`define L2ECR_ECTL_CRN 4'h9
`define L2ECR_ECTL_CRM 4'h0
`define L2ECR_ECTL_OPC2 3'h3
`define L2ECR_CONFIG_BASE_ADDRESS_OPC1 3'h4
`define L2ECR_CONFIG_BASE_ADDRESS_CRN 4'hf
`define L2ECR_CONFIG_BASE_ADDRESS_CRM 4'h0
`define L2ECR_CONFIG_BASE_ADDRESS_OPC2 3'h0
`define L2ECR_AMAIR_OPC1 3'h0
`define L2ECR_HAMAIR_OPC1 3'h4
`define L2ECR_AMAIR_CRN 4'ha
`define L2ECR_AMAIR_CRM 4'h3
`define L2ECR_AUX_ATTR_INDIRECTION_0_OPC2 3'h0
`define L2ECR_AUX_ATTR_INDIRECTION_1_OPC2 3'h1
`define L2ECR_FAST_CONTEXT_SWITCH_EXT_OPC1 3'h0
`define L2ECR_FAST_CONTEXT_SWITCH_EXT_CRN 4'hd
`define L2ECR_FAST_CONTEXT_SWITCH_EXT_CRM 4'h0
`define L2ECR_FAST_CONTEXT_SWITCH_EXT_OPC2 3'h0
`define L2ECR_AXIERR_BIT 29
`define L2ECR_AXIERR_RST 1'b0
`define L2ECR_BASE_LO_MSB 31
`define L2ECR_BASE_LO_LSB 15
`define L2ECR_BASE_HI_MSB 7
`define L2ECR_BASE_HI_LSB 0
`define L2ECR_UNK_VALUE 32'h0000_0000
`define L2ECR_ZERO 32'h0000_0000
`endif

// ==== rtl/l2ecr_err_flag.v ====
// Shared sticky asynchronous bus error flag
`timescale 1ns/1ps
`include "l2ecr_map.vh"
module l2ecr_err_flag (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire err_event_i,
   input wire clear_i,
   output reg flag_o
);
   reg next_flag;
   always @* begin
      next_flag = flag_o;
      if (clear_i) begin
         next_flag = 1'b0;
      end
      // Set beats clear so a same-cycle error is kept
      if (err_event_i) begin
         next_flag = 1'b1;
      end
   end
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         flag_o <= `L2ECR_AXIERR_RST;
      end else begin
         flag_o <= next_flag;
      end
   end
endmodule

// ==== rtl/l2ecr_regs.v ====
// Coprocessor 15 L2 extended control, base address and stub registers
// Operation
// - One extended control register instance is shared by all cores in the cluster.
// - The same register is seen in Secure and Non-secure state, with no banked copy.
// - Access needs privilege level 1 or above, with rights depending on mode.
// - Secure privilege level 1 may read and write the extended control register.
// - With the grant bit at 0, Non-secure PL1 and PL2 read normally and writes are ignored.
// - With the grant bit at 1, Non-secure PL1 and PL2 writes touch only the error bit.
// - Bit 29 is set when an asynchronous bus error occurs and is 0 while none is pending.
// - The error bit resets to 0.
// - A permitted write of 0 clears the error bit and a write of 1 has no effect.
// - The extended control register decodes as opcode1 1, CRn c9, CRm c0, opcode2 3.
// - The base register is read-only and maps address bits 31:15 and 39:32 into bits 31:15 and 7:0.
// - The base register decodes as opcode1 4, CRn c15, CRm c0, opcode2 0.
// - The auxiliary attribute indirection registers and hypervisor copies are stubs returning unknown.
// - The fast context switch process register reads zero and ignores writes.
`timescale 1ns/1ps
`include "l2ecr_map.vh"
module l2ecr_regs #(
   parameter NUM_CORES = 4
) (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire [NUM_CORES-1:0] cp_req_i,
   input wire [NUM_CORES-1:0] cp_write_i,
   input wire [NUM_CORES*4-1:0] cp_num_i,
   input wire [NUM_CORES*3-1:0] cp_opc1_i,
   input wire [NUM_CORES*4-1:0] cp_crn_i,
   input wire [NUM_CORES*4-1:0] cp_crm_i,
   input wire [NUM_CORES*3-1:0] cp_opc2_i,
   input wire [NUM_CORES*32-1:0] cp_wdata_i,
   input wire [NUM_CORES-1:0] cp_secure_i,
   input wire [NUM_CORES-1:0] cp_priv_i,
   input wire [NUM_CORES-1:0] nonsecure_l2_error_access_grant_i,
   input wire axi_async_error_i,
   input wire [39:0] peripheral_base_input_i,
   output reg [NUM_CORES-1:0] cp_ack_o,
   output reg [NUM_CORES-1:0] cp_undef_o,
   output reg [NUM_CORES*32-1:0] cp_rdata_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Decoder selectors
   localparam SEL_NONE = 3'h0;
   localparam SEL_ECTL = 3'h1;
   localparam SEL_CONFIG_BASE_ADDRESS = 3'h2;
   localparam SEL_STUB = 3'h3;
   localparam SEL_ZERO = 3'h4;

   // Shared decoder, used by every core port
   function [2:0] decode;
      input [3:0] num;
      input [2:0] opc1;
      input [3:0] crn;
      input [3:0] crm;
      input [2:0] opc2;
      begin
         decode = SEL_NONE;
         if (num == `L2ECR_CP_NUM) begin
            if (opc1 == `L2ECR_ECTL_OPC1 && crn == `L2ECR_ECTL_CRN && crm == `L2ECR_ECTL_CRM &&
                opc2 == `L2ECR_ECTL_OPC2) begin
               decode = SEL_ECTL;
            end else if (opc1 == `L2ECR_CONFIG_BASE_ADDRESS_OPC1 && crn == `L2ECR_CONFIG_BASE_ADDRESS_CRN &&
                         crm == `L2ECR_CONFIG_BASE_ADDRESS_CRM && opc2 == `L2ECR_CONFIG_BASE_ADDRESS_OPC2) begin
               decode = SEL_CONFIG_BASE_ADDRESS;
            end else if ((opc1 == `L2ECR_AMAIR_OPC1 || opc1 == `L2ECR_HAMAIR_OPC1) &&
                         crn == `L2ECR_AMAIR_CRN && crm == `L2ECR_AMAIR_CRM &&
                         (opc2 == `L2ECR_AUX_ATTR_INDIRECTION_0_OPC2 || opc2 == `L2ECR_AUX_ATTR_INDIRECTION_1_OPC2)) begin
               decode = SEL_STUB;
            end else if (opc1 == `L2ECR_FAST_CONTEXT_SWITCH_EXT_OPC1 && crn == `L2ECR_FAST_CONTEXT_SWITCH_EXT_CRN &&
                         crm == `L2ECR_FAST_CONTEXT_SWITCH_EXT_CRM && opc2 == `L2ECR_FAST_CONTEXT_SWITCH_EXT_OPC2) begin
               decode = SEL_ZERO;
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Read word for an accepted read, one per selector
   function [31:0] read_mux;
      input [2:0] sel;
      input [31:0] ectl_word;
      input [31:0] base_word;
      begin
         case (sel)
            SEL_ECTL: begin
               read_mux = ectl_word;
            end
            SEL_CONFIG_BASE_ADDRESS: begin
               read_mux = base_word;
            end
            SEL_STUB: begin
               read_mux = `L2ECR_UNK_VALUE;
            end
            SEL_ZERO: begin
               read_mux = `L2ECR_ZERO;
            end
            default: begin
               read_mux = `L2ECR_ZERO;
            end
         endcase
      end
   endfunction

   // Secure writes freely; Non-secure needs the grant, and only bit 29 exists anyway
   function write_granted;
      input secure;
      input grant;
      begin
         write_granted = 1'b0;
         if (secure) begin
            write_granted = 1'b1;
         end else if (grant) begin
            write_granted = 1'b1;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pins taken in reset and again on the first free edge, so late pins still land
   reg [39:0] base_capt;
   reg base_loaded;
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         base_capt <= peripheral_base_input_i;
         base_loaded <= 1'b0;
      end else if (!base_loaded) begin
         base_capt <= peripheral_base_input_i;
         base_loaded <= 1'b1;
      end
   end

   reg [31:0] config_base_address;
   always @* begin
      config_base_address = `L2ECR_ZERO;
      config_base_address[`L2ECR_BASE_LO_MSB:`L2ECR_BASE_LO_LSB] = base_capt[31:15];
      config_base_address[`L2ECR_BASE_HI_MSB:`L2ECR_BASE_HI_LSB] = base_capt[39:32];
   end

   ////////////////////////////////////////////////////////////////////////////
   wire [NUM_CORES-1:0] clr_vec;
   wire err_flag;
   wire any_clear;
   reg [31:0] l2_extended_control;
   // Only the error bit exists; the rest reads zero
   always @* begin
      l2_extended_control = `L2ECR_ZERO;
      l2_extended_control[`L2ECR_AXIERR_BIT] = err_flag;
   end
   assign any_clear = |clr_vec;

   genvar g;
   generate
      for (g = 0; g < NUM_CORES; g = g + 1) begin : g_core
         wire [2:0] sel;
         wire is_write;
         wire is_read;
         wire priv_ok;
         wire known;
         wire base_write;
         wire legal;
         wire wr_ok;
         wire clr_bit;
         reg next_ack;
         reg next_undef;
         reg [31:0] next_rdata;

         assign sel = decode(cp_num_i[g*4+:4], cp_opc1_i[g*3+:3], cp_crn_i[g*4+:4],
                             cp_crm_i[g*4+:4], cp_opc2_i[g*3+:3]);

         assign is_write = cp_req_i[g] && cp_write_i[g];
         assign is_read = cp_req_i[g] && !cp_write_i[g];
         assign priv_ok = cp_priv_i[g];
         assign known = sel != SEL_NONE;
         assign base_write = cp_write_i[g] && sel == SEL_CONFIG_BASE_ADDRESS;
         // Unprivileged or unknown encodings take the undefined path
         assign legal = priv_ok && known && !base_write;
         assign wr_ok = write_granted(cp_secure_i[g], nonsecure_l2_error_access_grant_i[g]);
         // Writing 1 to the error bit leaves it alone
         assign clr_bit = !cp_wdata_i[g*32+`L2ECR_AXIERR_BIT];
         assign clr_vec[g] = is_write && legal && sel == SEL_ECTL && wr_ok && clr_bit;

         always @* begin
            next_ack = 1'b0;
            next_undef = 1'b0;
            next_rdata = cp_rdata_o[g*32+:32];

            if (cp_req_i[g] && legal) begin
               next_ack = 1'b1;
            end
            if (cp_req_i[g] && !legal) begin
               next_undef = 1'b1;
            end
            // Refused reads and all writes keep the last word
            if (is_read && legal) begin
               next_rdata = read_mux(sel, l2_extended_control, config_base_address);
            end
         end

         always @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               cp_ack_o[g] <= 1'b0;
               cp_undef_o[g] <= 1'b0;
               cp_rdata_o[g*32+:32] <= `L2ECR_ZERO;
            end else begin
               cp_ack_o[g] <= next_ack;
               cp_undef_o[g] <= next_undef;
               cp_rdata_o[g*32+:32] <= next_rdata;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Single flag for the whole cluster; any core's clear reaches all
   l2ecr_err_flag u_err_flag (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .err_event_i(axi_async_error_i),
      .clear_i(any_clear),
      .flag_o(err_flag)
   );
endmodule

// ==== tb/l2ecr_regs_chk.sv ====
// Assertion checker for the L2 control and base registers, core 0 view
`timescale 1ns/1ps
module l2ecr_regs_chk #(
   parameter NUM_CORES = 4
) (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire [NUM_CORES-1:0] cp_req_i,
   input wire [NUM_CORES-1:0] cp_write_i,
   input wire [NUM_CORES*4-1:0] cp_num_i,
   input wire [NUM_CORES*3-1:0] cp_opc1_i,
   input wire [NUM_CORES*4-1:0] cp_crn_i,
   input wire [NUM_CORES*4-1:0] cp_crm_i,
   input wire [NUM_CORES*3-1:0] cp_opc2_i,
   input wire [NUM_CORES-1:0] cp_priv_i,
   input wire axi_async_error_i,
   input wire [39:0] peripheral_base_input_i,
   input wire [NUM_CORES-1:0] cp_ack_o,
   input wire [NUM_CORES-1:0] cp_undef_o,
   input wire [NUM_CORES*32-1:0] cp_rdata_o
);
   localparam [17:0] ECTL = 18'h3_cc83, CONFIG_BASE_ADDRESS = 18'h3_e780, FAST_CONTEXT_SWITCH_EXT = 18'h3_c680;
   wire [17:0] enc = {cp_num_i[3:0], cp_opc1_i[2:0], cp_crn_i[3:0], cp_crm_i[3:0], cp_opc2_i[2:0]};
   wire rq = cp_req_i[0] & cp_priv_i[0];
   wire rd = rq & ~cp_write_i[0];
   wire [31:0] d = cp_rdata_o[31:0];
   ////////////////////////////////////////
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   a_one_answer: assert property (cp_req_i[0] |=> cp_ack_o[0] ^ cp_undef_o[0]) else $error("bad answer");
   a_unpriv_refused: assert property (cp_req_i[0] && !cp_priv_i[0] |=> cp_undef_o[0]) else $error("unpriv");
   a_ectl_acked: assert property (rq && enc == ECTL |=> cp_ack_o[0]) else $error("ectl not acked");
   a_rsvd_zero: assert property (rd && enc == ECTL |=> d[31:30] == 2'h0 && d[28:0] == 29'h0)
      else $error("reserved bits set");
   a_base_value: assert property (rd && enc == CONFIG_BASE_ADDRESS |=> cp_ack_o[0] &&
      d == {$past(peripheral_base_input_i[31:15]), 7'h00, $past(peripheral_base_input_i[39:32])})
      else $error("base value");
   a_base_ro: assert property (rq && cp_write_i[0] && enc == CONFIG_BASE_ADDRESS |=> cp_undef_o[0]) else $error("base write");
   a_ctx_zero: assert property (rd && enc == FAST_CONTEXT_SWITCH_EXT |=> cp_ack_o[0] && d == 32'h0000_0000) else $error("ctx");
   a_err_seen: assert property ((axi_async_error_i && (cp_req_i & cp_write_i) == 0) ##1
      (cp_req_i & cp_write_i) == 0 ##1 (rd && enc == ECTL) |=> d[29]) else $error("error flag lost");
endmodule
bind l2ecr_regs l2ecr_regs_chk #(.NUM_CORES(NUM_CORES)) chk_inst (.sys_clk_i, .resetn_i, .cp_req_i, .cp_write_i,
   .cp_num_i, .cp_opc1_i, .cp_crn_i, .cp_crm_i, .cp_opc2_i, .cp_priv_i, .axi_async_error_i, .peripheral_base_input_i,
   .cp_ack_o, .cp_undef_o, .cp_rdata_o);

// ==== tb/tb_top.sv ====
// Self-checking bench for the L2 control and base registers
`timescale 1ns/1ps
module tb_top;
   localparam [17:0] ECTL = 18'h3_cc83, CONFIG_BASE_ADDRESS = 18'h3_e780, FAST_CONTEXT_SWITCH_EXT = 18'h3_c680, AMA0 = 18'h3_c518;
   // Hypervisor stub 1, and the control encoding on a foreign coprocessor
   localparam [17:0] HAM1 = 18'h3_e519, BADN = 18'h3_8c83;
   reg clk = 0, rst_n = 0, err = 0;
   reg [3:0] req = 0, wr = 0, sec = 0, priv = 0, gnt = 0;
   reg [15:0] num = 0, crn = 0, crm = 0;
   reg [11:0] opc1 = 0, opc2 = 0;
   reg [127:0] wd = 0;
   // Bits 14:8 nonzero so leaks into the gap show
   reg [39:0] pb = 40'h5a_a5c3_e7f1;
   wire [3:0] ack, und;
   wire [127:0] rdata;
   reg [33:0] res;
   integer n_fail = 0, num_checks = 0;
   l2ecr_regs l2ecr_regs_inst (.sys_clk_i(clk), .resetn_i(rst_n), .cp_req_i(req), .cp_write_i(wr), .cp_num_i(num),
      .cp_opc1_i(opc1), .cp_crn_i(crn), .cp_crm_i(crm), .cp_opc2_i(opc2), .cp_wdata_i(wd), .cp_secure_i(sec),
      .cp_priv_i(priv), .nonsecure_l2_error_access_grant_i(gnt), .axi_async_error_i(err),
      .peripheral_base_input_i(pb), .cp_ack_o(ack), .cp_undef_o(und), .cp_rdata_o(rdata));
   initial forever #5 clk = ~clk;
   ////////////////////////////////////////
   task finish_test;
      begin
         $display("checks %0d failures %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [33:0] got, input [33:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Mode m is {write, secure, priv, grant}; result is {ack, undef, rdata}
   task acc(input integer c, input [17:0] e, input [3:0] m, input [31:0] d);
      begin
         @(posedge clk); #1;
         {num[c*4+:4], opc1[c*3+:3], crn[c*4+:4], crm[c*4+:4], opc2[c*3+:3]} = e;
         {wr[c], sec[c], priv[c], gnt[c]} = m;
         wd[c*32+:32] = d;
         req[c] = 1'b1;
         @(posedge clk); #1;
         req[c] = 1'b0;
         res = {ack[c], und[c], rdata[c*32+:32]};
      end
   endtask
   task pulse;
      begin
         @(posedge clk); #1 err = 1'b1;
         @(posedge clk); #1 err = 1'b0;
      end
   endtask
   task t_base;
      begin
         acc(0, CONFIG_BASE_ADDRESS, 4'b0010, 0); chk(res, {2'b10, pb[31:15], 7'h00, pb[39:32]});
         acc(0, CONFIG_BASE_ADDRESS, 4'b1110, 32'hffff_ffff); chk(res, {2'b01, pb[31:15], 7'h00, pb[39:32]});
         acc(0, ECTL, 4'b0100, 0); chk(res, {2'b01, pb[31:15], 7'h00, pb[39:32]});
      end
   endtask
   task t_stub;
      begin
         acc(0, FAST_CONTEXT_SWITCH_EXT, 4'b1110, 32'hffff_ffff); chk(res, {2'b10, pb[31:15], 7'h00, pb[39:32]});
         acc(0, FAST_CONTEXT_SWITCH_EXT, 4'b0110, 0); chk(res, {2'b10, 32'h0000_0000});
         acc(0, AMA0, 4'b0010, 0); chk(res, {2'b10, 32'h0000_0000});
         acc(0, HAM1, 4'b0010, 0); chk(res, {2'b10, 32'h0000_0000});
         acc(0, BADN, 4'b0010, 0); chk(res, {2'b01, 32'h0000_0000});
      end
   endtask
   // Flag is shared, so one core's clear must show on another
   task t_err;
      begin
         acc(0, ECTL, 4'b0110, 0); chk(res, {2'b10, 32'h0000_0000});
         pulse;
         acc(0, ECTL, 4'b0010, 0); chk(res, {2'b10, 32'h2000_0000});
         acc(0, ECTL, 4'b1010, 0); chk(res, {2'b10, 32'h2000_0000});
         acc(0, ECTL, 4'b0010, 0); chk(res, {2'b10, 32'h2000_0000});
         acc(1, ECTL, 4'b1011, 32'hffff_ffff); chk(res, {2'b10, 32'h0000_0000});
         acc(0, ECTL, 4'b0010, 0); chk(res, {2'b10, 32'h2000_0000});
         acc(1, ECTL, 4'b1011, 32'hdfff_ffff); chk(res, {2'b10, 32'h0000_0000});
         acc(0, ECTL, 4'b0010, 0); chk(res, {2'b10, 32'h0000_0000});
         pulse;
         acc(2, ECTL, 4'b0110, 0); chk(res, {2'b10, 32'h2000_0000});
         acc(2, ECTL, 4'b1110, 0); chk(res, {2'b10, 32'h2000_0000});
         acc(3, ECTL, 4'b0010, 0); chk(res, {2'b10, 32'h0000_0000});
         // Error and clear in one cycle: the error must survive
         err = 1'b1;
         acc(1, ECTL, 4'b1011, 0); chk(res, {2'b10, 32'h0000_0000});
         err = 1'b0;
         acc(1, ECTL, 4'b0010, 0); chk(res, {2'b10, 32'h2000_0000});
      end
   endtask
   // Second reset with new pins: flag must clear, base must follow the pins
   task t_reset;
      begin
         pulse;
         @(posedge clk); #1 rst_n = 1'b0;
         pb = 40'h3c_96a5_0f0e;
         repeat (3) @(posedge clk);
         #1 rst_n = 1'b1;
         acc(0, ECTL, 4'b0110, 0); chk(res, {2'b10, 32'h0000_0000});
         acc(0, CONFIG_BASE_ADDRESS, 4'b0010, 0); chk(res, {2'b10, pb[31:15], 7'h00, pb[39:32]});
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      t_base;
      t_stub;
      t_err;
      t_reset;
      finish_test;
   end
   // About 23 accesses of two cycles each; far beyond that means a hang
   initial begin
      #20000;
      n_fail = n_fail + 1;
      finish_test;
   end
endmodule
